//--- hdl/etm_event_timer.sv
// Event counter, timer and pulse-width measurer with divider output.
`default_nettype none

module etm_event_timer
(
    input wire logic SYS_CLK,           // Core clock, 250 MHz.
    input wire logic RST_N,             // Synchronous reset, active low.
    input wire logic [7:0] ADDR,        // Register address.
    input wire logic [7:0] WDATA,       // Register write data.
    input wire logic WR_EN,             // Write strobe.
    input wire logic RD_EN,             // Read strobe.
    output logic [7:0] RDATA,           // Read data, one cycle after strobe.
    input wire logic COUNT_PIN,         // External count or pulse signal.
    input wire logic PORT_LINE3_IN,     // Shared port line, pin level.
    output logic PORT_LINE3_OUT,        // Shared port line, driven level.
    output logic PORT_LINE3_OE,         // Shared port line, drive enable.
    output logic OVF_IRQ,               // Overflow interrupt request level.
    output logic WAKE_REQ               // Overflow wake-up pulse.
);

    logic [7:0] count_value;
    logic [7:0] preload;
    logic [7:0] count_control;
    logic overflow_flag;
    logic overflow_int_enable;
    logic port_data;
    logic port_dir_in;
    logic pfd_option;
    logic freq_divider_out;

    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    logic pin_rise;
    logic pin_fall;

    logic [etm_pkg::PRESC_WIDTH-1:0] presc_cnt;
    logic [etm_pkg::PRESC_WIDTH-1:0] presc_mask;
    logic presc_tick;

    etm_pkg::etm_pw_state_type pw_state;
    etm_pkg::etm_pw_state_type next_pw_state;

    logic [1:0] mode;
    logic count_run;
    logic edge_polarity;
    logic [2:0] prescale_sel;

    logic wr_count;
    logic wr_control;
    logic wr_int;
    logic wr_port;
    logic rd_count;
    logic count_tick;
    logic overflow;
    logic pw_start_edge;
    logic pw_stop_edge;
    logic pw_done;

    assign mode = count_control[etm_pkg::MODE_HI_BIT:etm_pkg::MODE_LO_BIT];
    assign count_run = count_control[etm_pkg::RUN_BIT];
    assign edge_polarity = count_control[etm_pkg::EDGE_BIT];
    assign prescale_sel =
        count_control[etm_pkg::PRESC_HI_BIT:etm_pkg::PRESC_LO_BIT];

    assign wr_count = WR_EN && (ADDR == etm_pkg::COUNT_VALUE_ADDR);
    assign wr_control = WR_EN && (ADDR == etm_pkg::COUNT_CONTROL_ADDR);
    assign wr_int = WR_EN && (ADDR == etm_pkg::INT_CONTROL_ADDR);
    assign wr_port = WR_EN && (ADDR == etm_pkg::PORT_LINE_ADDR);
    assign rd_count = RD_EN && (ADDR == etm_pkg::COUNT_VALUE_ADDR);

    // Count pin synchroniser; only pin_sync and pin_prev feed the edges.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
            pin_prev <= 1'b0;
        end
        else
        begin
            pin_meta <= COUNT_PIN;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    assign pin_rise = pin_sync && !pin_prev;
    assign pin_fall = !pin_sync && pin_prev;

    // Free-running prescaler; a divide by 2^n gives a tick every 2^n cycles.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            presc_cnt <= '0;
        end
        else
        begin
            presc_cnt <= presc_cnt + 1'b1;
        end
    end

    always_comb
    begin
        presc_mask = '0;
        for (int i = 0; i < etm_pkg::PRESC_WIDTH; i++)
        begin
            presc_mask[i] = (i < int'(prescale_sel));
        end
    end

    assign presc_tick = ((presc_cnt & presc_mask) == presc_mask);

    // Pulse-width edges: polarity 1 measures a high pulse, 0 a low pulse.
    assign pw_start_edge = edge_polarity ? pin_rise : pin_fall;
    assign pw_stop_edge = edge_polarity ? pin_fall : pin_rise;

    always_comb
    begin
        next_pw_state = pw_state;
        unique case (pw_state)
            etm_pkg::PW_IDLE:
            begin
                if (count_run && mode == etm_pkg::MODE_PULSE)
                begin
                    next_pw_state = etm_pkg::PW_ARMED;
                end
            end
            etm_pkg::PW_ARMED:
            begin
                if (!count_run || mode != etm_pkg::MODE_PULSE)
                begin
                    next_pw_state = etm_pkg::PW_IDLE;
                end
                else if (pw_start_edge)
                begin
                    next_pw_state = etm_pkg::PW_MEASURE;
                end
            end
            etm_pkg::PW_MEASURE:
            begin
                if (!count_run || mode != etm_pkg::MODE_PULSE || pw_stop_edge)
                begin
                    next_pw_state = etm_pkg::PW_IDLE;
                end
            end
        endcase
    end

    assign pw_done = (pw_state == etm_pkg::PW_MEASURE) && pw_stop_edge
        && count_run && (mode == etm_pkg::MODE_PULSE);

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            pw_state <= etm_pkg::PW_IDLE;
        end
        else
        begin
            pw_state <= next_pw_state;
        end
    end

    // Source of the count tick per mode.
    always_comb
    begin
        count_tick = 1'b0;
        unique case (mode)
            etm_pkg::MODE_EVENT:
            begin
                count_tick = count_run
                    && (edge_polarity ? pin_fall : pin_rise);
            end
            etm_pkg::MODE_TIMER:
            begin
                count_tick = count_run && presc_tick;
            end
            etm_pkg::MODE_PULSE:
            begin
                count_tick = (pw_state == etm_pkg::PW_MEASURE) && count_run
                    && !pw_stop_edge && presc_tick;
            end
            etm_pkg::MODE_UNUSED:
            begin
                count_tick = 1'b0;
            end
        endcase
        // A counter read cycle drops its tick, trading a lost count for a steady value.
        if (rd_count)
        begin
            count_tick = 1'b0;
        end
    end

    assign overflow = count_tick
        && (count_value == etm_pkg::COUNT_TOP);

    // Counter and preload.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            count_value <= etm_pkg::COUNT_RESET;
        end
        else if (wr_count && !count_run)
        begin
            count_value <= WDATA;
        end
        else if (overflow)
        begin
            count_value <= preload;
        end
        else if (count_tick)
        begin
            count_value <= count_value + 8'h01;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            preload <= etm_pkg::PRELOAD_RESET;
        end
        else if (wr_count)
        begin
            preload <= WDATA;
        end
    end

    // Control register; the run bit is only cleared by hardware in pulse mode.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            count_control <= etm_pkg::CONTROL_RESET;
        end
        else if (wr_control)
        begin
            count_control <= WDATA;
            count_control[etm_pkg::UNUSED_BIT] <= 1'b0;
        end
        else if (pw_done)
        begin
            count_control[etm_pkg::RUN_BIT] <= 1'b0;
        end
    end

    // Overflow flag: an overflow in the clearing cycle still sets it.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            overflow_flag <= 1'b0;
            overflow_int_enable <= 1'b0;
        end
        else
        begin
            if (overflow)
            begin
                overflow_flag <= 1'b1;
            end
            else if (wr_int)
            begin
                overflow_flag <= WDATA[etm_pkg::OVF_FLAG_BIT];
            end
            if (wr_int)
            begin
                overflow_int_enable <= WDATA[etm_pkg::OVF_ENABLE_BIT];
            end
        end
    end

    // Shared port line and frequency divider.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            freq_divider_out <= 1'b0;
        end
        else if (overflow)
        begin
            freq_divider_out <= !freq_divider_out;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            port_data <= etm_pkg::PORT_RESET[etm_pkg::PORT_DATA_BIT];
            port_dir_in <= etm_pkg::PORT_RESET[etm_pkg::PORT_DIR_BIT];
            pfd_option <= etm_pkg::PORT_RESET[etm_pkg::PORT_PFD_OPT_BIT];
        end
        else if (wr_port)
        begin
            port_data <= WDATA[etm_pkg::PORT_DATA_BIT];
            port_dir_in <= WDATA[etm_pkg::PORT_DIR_BIT];
            pfd_option <= WDATA[etm_pkg::PORT_PFD_OPT_BIT];
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            PORT_LINE3_OUT <= 1'b0;
            PORT_LINE3_OE <= 1'b0;
        end
        else
        begin
            PORT_LINE3_OE <= !port_dir_in;
            PORT_LINE3_OUT <= pfd_option ? (port_data && freq_divider_out)
                : port_data;
        end
    end

    // Interrupt request and wake-up pulse.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            OVF_IRQ <= 1'b0;
            WAKE_REQ <= 1'b0;
        end
        else
        begin
            OVF_IRQ <= (overflow_flag || overflow)
                && overflow_int_enable;
            WAKE_REQ <= overflow;
        end
    end

    // Register read port; unmapped addresses read as zero.
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            RDATA <= 8'h00;
        end
        else if (RD_EN)
        begin
            unique case (ADDR)
                etm_pkg::COUNT_VALUE_ADDR:
                begin
                    RDATA <= count_value;
                end
                etm_pkg::COUNT_CONTROL_ADDR:
                begin
                    RDATA <= count_control & 8'hdf;
                end
                etm_pkg::INT_CONTROL_ADDR:
                begin
                    RDATA <= 8'h00;
                    RDATA[etm_pkg::OVF_FLAG_BIT] <= overflow_flag;
                    RDATA[etm_pkg::OVF_ENABLE_BIT] <= overflow_int_enable;
                end
                etm_pkg::PORT_LINE_ADDR:
                begin
                    RDATA <= 8'h00;
                    RDATA[etm_pkg::PORT_DATA_BIT] <= port_data;
                    RDATA[etm_pkg::PORT_DIR_BIT] <= port_dir_in;
                    RDATA[etm_pkg::PORT_PFD_OPT_BIT] <= pfd_option;
                    RDATA[etm_pkg::PORT_PIN_BIT] <= PORT_LINE3_IN;
                end
                default:
                begin
                    RDATA <= 8'h00;
                end
            endcase
        end
        else
        begin
            RDATA <= 8'h00;
        end
    end

endmodule

`default_nettype wire

//--- hdl/etm_pkg.sv
// Constants shared by the event timer with pulse measurement.
//
// Overview of operation
// - An 8-bit up-counter clocked by the count pin or the prescaled clock.
// - Counter writes go to preload; counter reads return the live count.
// - Control bits 7:6 pick mode: 01 event, 10 timer, 11 pulse width.
// - Event or timer mode counts to FFH, then reloads and sets the flag.
// - Event mode counts pin edges; timer and pulse modes count prescaled ticks.
// - Pulse mode starts on the active edge, stops on return, clears run.
// - Pulse measurement starts on an edge only, never on a standing level.
// - One measurement per run setting; the result then holds in the counter.
// - Overflow during pulse measurement reloads and raises the flag as well.
// - Event mode: edge polarity 1 counts falling edges, 0 rising edges.
// - Pulse mode: polarity 1 measures high pulses, 0 measures low pulses.
// - Bit 4 enables counting; only software clears it outside pulse mode.
// - Control bits 2:0 divide the core clock by two to that power.
// - Control bit 5 is unused and reads as zero.
// - Preload writes also load the counter only while counting is off.
// - A counter read blocks the count tick of that cycle.
// - Every overflow is a wake-up request, in every mode.
// - Overflow interrupt enable at 0 suppresses the interrupt request.
// - Divider option, output mode: data 1 gives divider, data 0 gives low.
// - In input mode the shared line stays a plain input.
// - The divider output toggles on each overflow.
`default_nettype none

package etm_pkg;

    localparam logic [7:0] COUNT_VALUE_ADDR = 8'h0d;
    localparam logic [7:0] COUNT_CONTROL_ADDR = 8'h0e;
    localparam logic [7:0] INT_CONTROL_ADDR = 8'h0f;
    localparam logic [7:0] PORT_LINE_ADDR = 8'h10;

    localparam int MODE_HI_BIT = 7;
    localparam int MODE_LO_BIT = 6;
    localparam int UNUSED_BIT = 5;
    localparam int RUN_BIT = 4;
    localparam int EDGE_BIT = 3;
    localparam int PRESC_HI_BIT = 2;
    localparam int PRESC_LO_BIT = 0;

    localparam int OVF_FLAG_BIT = 5;
    localparam int OVF_ENABLE_BIT = 2;

    localparam int PORT_DATA_BIT = 0;
    localparam int PORT_DIR_BIT = 1;
    localparam int PORT_PFD_OPT_BIT = 2;
    localparam int PORT_PIN_BIT = 7;

    localparam logic [1:0] MODE_UNUSED = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_TIMER = 2'h2;
    localparam logic [1:0] MODE_PULSE = 2'h3;

    localparam logic [7:0] CONTROL_RESET = 8'h08;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] PRELOAD_RESET = 8'h00;
    localparam logic [7:0] COUNT_TOP = 8'hff;
    localparam logic [2:0] PORT_RESET = 3'h3;

    localparam int PRESC_WIDTH = 7;

    typedef enum logic [1:0] {
        PW_IDLE,
        PW_ARMED,
        PW_MEASURE
    } etm_pw_state_type;

endpackage

`default_nettype wire

//--- tb/etm_pin_model.sv
// Source of the external count signal: a resting level plus pulses.
`default_nettype none
module etm_pin_model
(
    input wire logic clk, // Core clock.
    input wire logic idle, // Level between pulses.
    input wire logic go, // Starts one pulse.
    input wire logic [7:0] width, // Pulse length in cycles.
    output logic pin // Drives the count pin.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left = 8'h00;
    // Pulses below two cycles would vanish in the synchroniser.
    always_ff @(posedge clk)
    begin
        if (go)
            left <= (width < 8'h02) ? 8'h02 : width;
        else if (left != 8'h00)
            left <= left - 8'h01;
    end
    assign pin = idle ^ (left != 8'h00);
endmodule
`default_nettype wire

//--- tb/etm_assertions.sv
// Checker on the register port, port line and overflow outputs.
`default_nettype none
module etm_assertions
(
    input wire logic SYS_CLK, // Core clock.
    input wire logic RST_N, // Reset, active low.
    input wire logic [7:0] ADDR, // Register address.
    input wire logic [7:0] WDATA, // Write data.
    input wire logic WR_EN, // Write strobe.
    input wire logic RD_EN, // Read strobe.
    input wire logic [7:0] RDATA, // Read data.
    input wire logic PORT_LINE3_OUT, // Driven line level.
    input wire logic PORT_LINE3_OE, // Line drive enable.
    input wire logic OVF_IRQ, // Interrupt request.
    input wire logic WAKE_REQ // Wake-up pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    logic w_port;
    logic w_int;
    assign w_port = WR_EN && ADDR == etm_pkg::PORT_LINE_ADDR;
    assign w_int = WR_EN && ADDR == etm_pkg::INT_CONTROL_ADDR;
    a_rdata_idle: assert property (!$past(RD_EN) |-> RDATA == 8'h00)
        else $error("read data outside its cycle");
    a_unused_bit: assert property ($past(RD_EN) &&
        $past(ADDR) == etm_pkg::COUNT_CONTROL_ADDR |-> !RDATA[5])
        else $error("unused control bit reads one");
    a_wake_pulse: assert property (WAKE_REQ |=> !WAKE_REQ)
        else $error("wake request longer than a cycle");
    a_wake_irq: assert property ($rose(OVF_IRQ) &&
        !$past(WR_EN) && !$past(WR_EN, 2) |-> WAKE_REQ)
        else $error("request raised without overflow");
    a_irq_masked: assert property ((w_int && !WDATA[2])
        ##1 !w_int |=> !OVF_IRQ)
        else $error("request with enable cleared");
    a_line_input: assert property ((w_port && WDATA[1])
        ##1 !w_port |=> !PORT_LINE3_OE)
        else $error("line driven in input mode");
    a_line_low: assert property ((w_port && WDATA[1:0] == 2'h0)
        ##1 !w_port |=> PORT_LINE3_OE && !PORT_LINE3_OUT)
        else $error("line not held low");
    a_div_toggle: assert property (PORT_LINE3_OE &&
        $past(PORT_LINE3_OE) && $changed(PORT_LINE3_OUT) &&
        !$past(WR_EN, 2) |-> $past(WAKE_REQ))
        else $error("divider moved without overflow");
    c_wake: cover property (WAKE_REQ);
    c_irq: cover property ($rose(OVF_IRQ));
    c_release: cover property (PORT_LINE3_OE ##1 !PORT_LINE3_OE);
endmodule
bind etm_event_timer etm_assertions chk_u (.SYS_CLK(SYS_CLK),
    .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .RDATA(RDATA), .PORT_LINE3_OUT(PORT_LINE3_OUT),
    .PORT_LINE3_OE(PORT_LINE3_OE), .OVF_IRQ(OVF_IRQ),
    .WAKE_REQ(WAKE_REQ));
`default_nettype wire

//--- tb/tb_event_timer_with_pulse_measure.sv
// Self-checking bench for the event timer with pulse measurement.
`default_nettype none
module tb_event_timer_with_pulse_measure;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] c; logic [7:0] e;} etm_row_type;
    localparam logic [7:0] A_CNT = etm_pkg::COUNT_VALUE_ADDR;
    localparam logic [7:0] A_CTL = etm_pkg::COUNT_CONTROL_ADDR;
    localparam logic [7:0] A_INT = etm_pkg::INT_CONTROL_ADDR;
    localparam logic [7:0] A_PRT = etm_pkg::PORT_LINE_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic go = 1'b0;
    logic [7:0] width = 8'h00;
    logic idle_lvl = 1'b0;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [7:0] d2;
    logic pin;
    logic line;
    logic l_out;
    logic l_oe;
    logic irq;
    logic wake;
    int n_errors = 0;
    int n_tests = 0;
    // Each run lasts 128 cycles, so every divider gives a whole count.
    etm_row_type rows [11] = '{'{8'h90, 8'h80}, '{8'h91, 8'h40},
        '{8'h92, 8'h20}, '{8'h93, 8'h10}, '{8'h94, 8'h08},
        '{8'h95, 8'h04}, '{8'h96, 8'h02}, '{8'h97, 8'h01},
        '{8'h10, 8'h00}, '{8'h50, 8'h00}, '{8'hb0, 8'h80}};
    // The line has a pull-up, so a released line reads high.
    assign line = l_oe ? l_out : 1'b1;
    always #2 clk = ~clk;
    etm_pin_model pin_u (.clk(clk), .idle(idle_lvl), .go(go),
        .width(width), .pin(pin));
    etm_event_timer dut_u (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata),
        .COUNT_PIN(pin), .PORT_LINE3_IN(line), .PORT_LINE3_OUT(l_out),
        .PORT_LINE3_OE(l_oe), .OVF_IRQ(irq), .WAKE_REQ(wake));
    task automatic end_sim();
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic pulse(input logic [7:0] w);
        @(posedge clk);
        width <= w;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task automatic wait_wake();
        int k = 0;
        while (wake !== 1'b1 && k < 4000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 4000)
        begin
            n_errors++;
            $display("unexpected at %0t: no wake-up", $time);
            end_sim();
        end
    endtask
    task automatic pw(input logic [7:0] c, input logic lv);
        logic [7:0] v;
        idle_lvl <= lv;
        cycles(4);
        wr(A_CNT, 8'h00);
        wr(A_CTL, c);
        cycles(4);
        pulse(8'h28);
        cycles(60);
        rd(A_CNT, v);
        chk(v, 8'h27);
        rd(A_CTL, d);
        chk(d, c & 8'hef);
        pulse(8'h28);
        cycles(60);
        rd(A_CNT, d);
        chk(d, v);
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            wr(A_CNT, 8'h00);
            wr(A_CTL, rows[i].c);
            rd(A_CTL, d);
            chk(d, rows[i].c & 8'hdf);
            cycles(124);
            wr(A_CTL, rows[i].c & 8'hef);
            rd(A_CNT, d);
            chk(d, rows[i].e);
        end
        // Back-to-back reads at divide by 1: the read cycles lose their ticks.
        wr(A_CTL, 8'h90);
        rd(A_CNT, d);
        rd(A_CNT, d2);
        chk(d2, d + 8'h01);
        wr(A_CTL, 8'h80);
        wr(A_INT, 8'h04);
        wr(A_PRT, 8'h05);
        wr(A_CNT, 8'hfc);
        wr(A_CTL, 8'h93);
        wait_wake();
        chk({7'h00, irq}, 8'h01);
        // The line register trails the divider flip-flop by one cycle.
        cycles(1);
        chk({6'h00, l_oe, l_out}, 8'h03);
        rd(A_INT, d);
        chk(d, 8'h24);
        wr(A_INT, 8'h00);
        wr(A_CNT, 8'h40);
        rd(A_CNT, d);
        chk(d & 8'hfc, 8'hfc);
        wait_wake();
        chk({7'h00, irq}, 8'h00);
        rd(A_CNT, d);
        chk(d, 8'h40);
        wr(A_PRT, 8'h04);
        cycles(2);
        chk({6'h00, l_oe, l_out}, 8'h02);
        wr(A_PRT, 8'h06);
        cycles(2);
        chk({7'h00, l_oe}, 8'h00);
        rd(A_PRT, d);
        chk(d, 8'h86);
        wr(A_CTL, 8'h83);
        for (int p = 0; p < 2; p++)
        begin
            wr(A_CNT, 8'h00);
            wr(A_CTL, 8'h50 | 8'(p * 8));
            pulse(8'h1e);
            cycles(15);
            wr(A_CTL, 8'h40 | 8'(p * 8));
            rd(A_CNT, d);
            chk(d, 8'(1 - p));
            cycles(20);
        end
        pw(8'hd8, 1'b0);
        pw(8'hd0, 1'b1);
        wr(A_CNT, 8'h00);
        wr(A_CTL, 8'hd8);
        cycles(30);
        rd(A_CNT, d);
        chk(d, 8'h00);
        idle_lvl <= 1'b0;
        cycles(10);
        rd(A_CNT, d);
        chk(d, 8'h00);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(A_CTL, d);
        chk(d, etm_pkg::CONTROL_RESET);
        rd(A_CNT, d);
        chk(d, etm_pkg::COUNT_RESET);
        rd(A_INT, d);
        chk(d, 8'h00);
        rd(A_PRT, d);
        chk(d, 8'h83);
        rd(8'h20, d);
        chk(d, 8'h00);
        end_sim();
    end
endmodule
`default_nettype wire
